// *** aux_thresh_map.svh ***
`ifndef AUX_THRESH_MAP_SVH
`define AUX_THRESH_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define AUX_CONV_CTRL_IDX      8'h3c
`define TEMP_CTRL_IDX          8'h3d
`define ACT_THR_UPPER_IDX      8'h3e
`define ACT_THR_LOWER_IDX      8'h3f
`define INACT_THR_UPPER_IDX    8'h40
`define INACT_THR_LOWER_IDX    8'h41
`define SAMPLE_COUNT_IDX       8'h42
`define EVENT_STATUS_IDX       8'h50

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AUX_CONV_CTRL_RST      8'hc0
`define TEMP_CTRL_RST          8'h00
`define THR_RST                8'h00

// ----------------------------------------------------------------
// Writable bit masks
// ----------------------------------------------------------------
`define AUX_CONV_CTRL_WMASK    8'hcf
`define TEMP_CTRL_WMASK        8'h0f
`define THR_UPPER_WMASK        8'h7f
`define THR_LOWER_WMASK        8'hfc
`define SAMPLE_COUNT_WMASK     8'hff

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CONV_EN_BIT            0
`define ACT_EN_BIT             1
`define INACT_EN_BIT           3
`define FMT_HI                 7
`define FMT_LO                 6

`endif

// *** aux_thresh_pkg.sv ***
package aux_thresh_pkg;

    // FIFO read-out presentation
    typedef enum logic [1:0] {
        FMT_LEGACY = 2'h0,
        FMT_8BIT   = 2'h1,
        FMT_12BIT  = 2'h2,
        FMT_FULL   = 2'h3
    } fifo_readout_format_t;

    // Per-channel detector state
    typedef enum logic [1:0] {
        DET_IDLE,
        DET_ACTIVE,
        DET_INACTIVE
    } det_state_t;

endpackage

// *** aux_event_detector.sv ***
`timescale 1ns/100ps
`include "aux_thresh_map.svh"

module aux_event_detector
    import aux_thresh_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        sample_valid,
    input  wire logic [13:0] sample,
    input  wire logic        act_enable,
    input  wire logic        inact_enable,
    input  wire logic [12:0] activity_threshold,
    input  wire logic [12:0] inactivity_threshold,
    input  wire logic [3:0]  activity_sample_count,
    input  wire logic [3:0]  inactivity_sample_count,
    output logic             act_event,
    output logic             inact_event
);

    logic [13:0] magnitude;
    logic        above;
    logic        below;
    logic [3:0]  act_run_reg;
    logic [3:0]  inact_run_reg;
    logic [4:0]  act_run_next;
    logic [4:0]  inact_run_next;

    // Absolute value of the signed sample, compared as raw codes
    always_comb begin
        magnitude = sample[13] ? 14'((~sample) + 14'h0001) : sample;
        above = magnitude > {1'b0, activity_threshold};
        below = magnitude < {1'b0, inactivity_threshold};
        act_run_next   = {1'b0, act_run_reg} + 5'h01;
        inact_run_next = {1'b0, inact_run_reg} + 5'h01;
    end

    // Consecutive-sample runs; a pulse on each qualifying sample once the run reaches the count
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            act_run_reg   <= 4'h0;
            inact_run_reg <= 4'h0;
            act_event     <= 1'b0;
            inact_event   <= 1'b0;
        end else begin
            act_event   <= 1'b0;
            inact_event <= 1'b0;
            if (sample_valid) begin
                if (act_enable && above) begin
                    if (act_run_next >= {1'b0, activity_sample_count}) begin
                        act_event <= 1'b1;
                    end
                    if (act_run_reg != 4'hf) begin
                        act_run_reg <= act_run_next[3:0];
                    end
                end else begin
                    act_run_reg <= 4'h0;
                end
                if (inact_enable && below) begin
                    if (inact_run_next >= {1'b0, inactivity_sample_count}) begin
                        inact_event <= 1'b1;
                    end
                    if (inact_run_reg != 4'hf) begin
                        inact_run_reg <= inact_run_next[3:0];
                    end
                end else begin
                    inact_run_reg <= 4'h0;
                end
            end
        end
    end

endmodule // aux_event_detector

// *** aux_temp_channel_threshold_regs.sv ***
// Functional notes
// - FIFO always stores full 14-bit samples; only read-out presentation changes.
// - Format 00 gives legacy word with low and high bytes swapped.
// - Format 01 gives upper 8 bits, no channel id.
// - Format 10 gives upper 12 bits, no channel id.
// - Format 11, reset value, gives 14 bits plus channel id.
// - Aux control bit 0 enables external ADC unless temperature enable set.
// - Aux control bit 3 enables inactivity, bit 1 activity on ADC channel.
// - Temperature bit 0 converts temperature with each acceleration sample.
// - Temperature bit 1 enables temperature activity detection.
// - Temperature bit 3 enables temperature inactivity detection.
// - Activity compares sample magnitude with unsigned 13-bit threshold.
// - Activity threshold bits 12:6 from upper 6:0, 5:0 from lower 7:2.
// - Inactivity compares magnitude with 13-bit threshold, upper bits from upper register.
// - Thresholds are raw codes, one LSB per code.
// - Inactivity threshold bits 5:0 from lower register bits 7:2.
// - Activity event after activity count consecutive samples above threshold.
// - Inactivity event after inactivity count consecutive samples below threshold.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`include "aux_thresh_map.svh"

module aux_temp_channel_threshold_regs
    import aux_thresh_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Sample path
    input  wire logic        accel_sample_strobe,
    input  wire logic [13:0] adc_sample,
    input  wire logic [13:0] temp_sample,
    input  wire logic [13:0] fifo_sample,
    input  wire logic [1:0]  fifo_channel_id,
    input  wire logic        fifo_read,
    // Conversion control and events
    output logic             adc_convert_enable,
    output logic             temp_convert_request,
    output logic [15:0]      fifo_readout_word,
    output logic             adc_act_event,
    output logic             adc_inact_event,
    output logic             temp_act_event,
    output logic             temp_inact_event
);

    // ----------------------------------------------------------------
    // Address decode helpers
    // ----------------------------------------------------------------

    // Word index from a byte address; all ones (unmapped) when not word aligned
    function automatic logic [7:0] word_index(input logic [11:0] addr);
        word_index = (addr[1:0] == 2'h0) ? addr[9:2] : 8'hff;
    endfunction

    // True for any index this block answers
    function automatic logic index_mapped(input logic [7:0] idx);
        index_mapped = (idx >= `AUX_CONV_CTRL_IDX && idx <= `SAMPLE_COUNT_IDX) ||
                       (idx == `EVENT_STATUS_IDX);
    endfunction

    logic [7:0]  aux_conversion_control_reg;
    logic [7:0]  temperature_channel_control_reg;
    logic [7:0]  activity_threshold_upper_reg;
    logic [7:0]  activity_threshold_lower_reg;
    logic [7:0]  inactivity_threshold_upper_reg;
    logic [7:0]  inactivity_threshold_lower_reg;
    logic [7:0]  sample_count_reg;
    logic [3:0]  event_status_reg;
    logic [7:0]  idx;
    logic        access;
    logic        wr_en;
    logic [7:0]  wdata;
    logic [7:0]  rdata_next;
    logic [12:0] activity_threshold;
    logic [12:0] inactivity_threshold;
    logic        temp_en;
    logic        adc_en;
    logic        adc_sample_valid;
    logic        temp_sample_valid;
    logic [3:0]  event_pulses;
    fifo_readout_format_t fifo_readout_format;

    // ----------------------------------------------------------------
    // APB access: zero wait states, error on unmapped address
    // ----------------------------------------------------------------

    // Access phase qualifiers
    always_comb begin
        idx    = word_index(paddr);
        access = psel && penable;
        wr_en  = access && pwrite && index_mapped(idx);
        wdata  = pwdata[7:0];
        pready = 1'b1;
        pslverr = access && !index_mapped(idx);
    end

    // Aux conversion control, masked write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aux_conversion_control_reg <= `AUX_CONV_CTRL_RST;
        end else if (wr_en && idx == `AUX_CONV_CTRL_IDX) begin
            aux_conversion_control_reg <= wdata & `AUX_CONV_CTRL_WMASK;
        end
    end

    // Temperature channel control, masked write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            temperature_channel_control_reg <= `TEMP_CTRL_RST;
        end else if (wr_en && idx == `TEMP_CTRL_IDX) begin
            temperature_channel_control_reg <= wdata & `TEMP_CTRL_WMASK;
        end
    end

    // Threshold registers, reserved bits forced to zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            activity_threshold_upper_reg   <= `THR_RST;
            activity_threshold_lower_reg   <= `THR_RST;
            inactivity_threshold_upper_reg <= `THR_RST;
            inactivity_threshold_lower_reg <= `THR_RST;
        end else if (wr_en) begin
            if (idx == `ACT_THR_UPPER_IDX) begin
                activity_threshold_upper_reg <= wdata & `THR_UPPER_WMASK;
            end
            if (idx == `ACT_THR_LOWER_IDX) begin
                activity_threshold_lower_reg <= wdata & `THR_LOWER_WMASK;
            end
            if (idx == `INACT_THR_UPPER_IDX) begin
                inactivity_threshold_upper_reg <= wdata & `THR_UPPER_WMASK;
            end
            if (idx == `INACT_THR_LOWER_IDX) begin
                inactivity_threshold_lower_reg <= wdata & `THR_LOWER_WMASK;
            end
        end
    end

    // Consecutive-sample counts: inactivity in the high nibble
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sample_count_reg <= `THR_RST;
        end else if (wr_en && idx == `SAMPLE_COUNT_IDX) begin
            sample_count_reg <= wdata & `SAMPLE_COUNT_WMASK;
        end
    end

    // Sticky event flags; set wins over write-one-to-clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            event_status_reg <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (event_pulses[i]) begin
                    event_status_reg[i] <= 1'b1;
                end else if (wr_en && idx == `EVENT_STATUS_IDX && wdata[i]) begin
                    event_status_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Read multiplexer
    always_comb begin
        unique case (idx)
            `AUX_CONV_CTRL_IDX:   rdata_next = aux_conversion_control_reg;
            `TEMP_CTRL_IDX:       rdata_next = temperature_channel_control_reg;
            `ACT_THR_UPPER_IDX:   rdata_next = activity_threshold_upper_reg;
            `ACT_THR_LOWER_IDX:   rdata_next = activity_threshold_lower_reg;
            `INACT_THR_UPPER_IDX: rdata_next = inactivity_threshold_upper_reg;
            `INACT_THR_LOWER_IDX: rdata_next = inactivity_threshold_lower_reg;
            `SAMPLE_COUNT_IDX:    rdata_next = sample_count_reg;
            `EVENT_STATUS_IDX:    rdata_next = {4'h0, event_status_reg};
            default:              rdata_next = 8'h00;
        endcase
    end

    // Read data registered in the setup phase, valid in access phase
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, rdata_next};
        end
    end

    // ----------------------------------------------------------------
    // Conversion control and threshold assembly
    // ----------------------------------------------------------------

    // Field extraction
    always_comb begin
        temp_en = temperature_channel_control_reg[`CONV_EN_BIT];
        adc_en  = aux_conversion_control_reg[`CONV_EN_BIT] && !temp_en;
        fifo_readout_format = fifo_readout_format_t'(
            aux_conversion_control_reg[`FMT_HI:`FMT_LO]);
        activity_threshold = {activity_threshold_upper_reg[6:0],
                              activity_threshold_lower_reg[7:2]};
        inactivity_threshold = {inactivity_threshold_upper_reg[6:0],
                                inactivity_threshold_lower_reg[7:2]};
        adc_sample_valid  = accel_sample_strobe && adc_en;
        temp_sample_valid = accel_sample_strobe && temp_en;
        event_pulses      = {temp_inact_event, temp_act_event, adc_inact_event, adc_act_event};
    end

    // Conversion outputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            adc_convert_enable   <= 1'b0;
            temp_convert_request <= 1'b0;
        end else begin
            adc_convert_enable   <= adc_en;
            temp_convert_request <= accel_sample_strobe && temp_en;
        end
    end

    // ----------------------------------------------------------------
    // FIFO read-out presentation; storage stays 14 bits wide
    // ----------------------------------------------------------------

    // Word formatting of the stored sample
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fifo_readout_word <= 16'h0000;
        end else if (fifo_read) begin
            unique case (fifo_readout_format)
                FMT_LEGACY: fifo_readout_word <= {fifo_sample[5:0], fifo_channel_id,
                                                  {2{fifo_sample[13]}}, fifo_sample[13:8]};
                FMT_8BIT:   fifo_readout_word <= {8'h00, fifo_sample[13:6]};
                FMT_12BIT:  fifo_readout_word <= {4'h0, fifo_sample[13:2]};
                FMT_FULL:   fifo_readout_word <= {fifo_channel_id, fifo_sample};
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Channel detectors
    // ----------------------------------------------------------------

    // External ADC channel
    aux_event_detector u_adc_det (
        .sys_clk                 (sys_clk),
        .rst                     (rst),
        .sample_valid            (adc_sample_valid),
        .sample                  (adc_sample),
        .act_enable              (aux_conversion_control_reg[`ACT_EN_BIT]),
        .inact_enable            (aux_conversion_control_reg[`INACT_EN_BIT]),
        .activity_threshold      (activity_threshold),
        .inactivity_threshold    (inactivity_threshold),
        .activity_sample_count   (sample_count_reg[3:0]),
        .inactivity_sample_count (sample_count_reg[7:4]),
        .act_event               (adc_act_event),
        .inact_event             (adc_inact_event)
    );

    // Temperature channel
    aux_event_detector u_temp_det (
        .sys_clk                 (sys_clk),
        .rst                     (rst),
        .sample_valid            (temp_sample_valid),
        .sample                  (temp_sample),
        .act_enable              (temperature_channel_control_reg[`ACT_EN_BIT]),
        .inact_enable            (temperature_channel_control_reg[`INACT_EN_BIT]),
        .activity_threshold      (activity_threshold),
        .inactivity_threshold    (inactivity_threshold),
        .activity_sample_count   (sample_count_reg[3:0]),
        .inactivity_sample_count (sample_count_reg[7:4]),
        .act_event               (temp_act_event),
        .inact_event             (temp_inact_event)
    );

endmodule // aux_temp_channel_threshold_regs

// *** aux_temp_channel_threshold_regs_sva.sv ***
`timescale 1ns/100ps

module aux_temp_channel_threshold_regs_sva (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        accel_sample_strobe,
    input wire logic        fifo_read,
    input wire logic        adc_convert_enable,
    input wire logic        temp_convert_request,
    input wire logic [15:0] fifo_readout_word,
    input wire logic        adc_act_event,
    input wire logic        adc_inact_event,
    input wire logic        temp_act_event,
    input wire logic        temp_inact_event
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Read setup followed by its access phase
    sequence s_read;
        psel && !penable && !pwrite ##1 psel && penable;
    endsequence
    property p_read_clean;
        s_read |-> pready && prdata[31:8] == 24'h0;
    endproperty
    property p_misalign;
        psel && penable && paddr[1:0] != 2'h0 |-> pslverr;
    endproperty
    property p_excl;
        temp_convert_request |-> !adc_convert_enable;
    endproperty
    property p_tconv;
        temp_convert_request |-> $past(accel_sample_strobe);
    endproperty
    property p_adc_act;
        adc_act_event |-> adc_convert_enable && $past(accel_sample_strobe);
    endproperty
    property p_adc_inact;
        adc_inact_event |-> adc_convert_enable && $past(accel_sample_strobe);
    endproperty
    property p_temp_act;
        temp_act_event |-> temp_convert_request;
    endproperty
    property p_temp_inact;
        temp_inact_event |-> temp_convert_request;
    endproperty
    property p_word_hold;
        !$past(fifo_read) |-> $stable(fifo_readout_word);
    endproperty

    a_read_clean: assert property (p_read_clean) else $error("read word upper bits set");
    a_misalign: assert property (p_misalign) else $error("misaligned access not refused");
    a_excl: assert property (p_excl) else $error("adc enabled during temp conversion");
    a_tconv: assert property (p_tconv) else $error("temp request without strobe");
    a_adc_act: assert property (p_adc_act) else $error("adc activity while disabled");
    a_adc_inact: assert property (p_adc_inact) else $error("adc inactivity while disabled");
    a_temp_act: assert property (p_temp_act) else $error("temp activity without conversion");
    a_temp_inact: assert property (p_temp_inact) else $error("temp inactivity without conversion");
    a_word_hold: assert property (p_word_hold) else $error("readout word moved without read");
endmodule // aux_temp_channel_threshold_regs_sva

// *** aux_temp_channel_threshold_regs_tb.sv ***
`timescale 1ns/100ps
`include "aux_thresh_map.svh"

module aux_temp_channel_threshold_regs_tb
    import aux_thresh_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic        pready, pslverr;
    logic [31:0] prdata;
    logic        accel_sample_strobe = 1'b0, fifo_read = 1'b0;
    logic [13:0] adc_sample = 14'h0, temp_sample = 14'h0, fifo_sample = 14'h0;
    logic [1:0]  fifo_channel_id = 2'h0;
    logic        adc_convert_enable, temp_convert_request;
    logic        adc_act_event, adc_inact_event, temp_act_event, temp_inact_event;
    logic [15:0] fifo_readout_word;
    int          n_errors = 0, checks_done = 0, cycles = 0;
    logic [7:0]  idx_tab [7] = '{8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42};
    logic [7:0]  rst_tab [7] = '{8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]  msk_tab [7] = '{8'hcf, 8'h0f, 8'h7f, 8'hfc, 8'h7f, 8'hfc, 8'hff};
    logic [13:0] smp_tab [12] = '{14'h0106, 14'h3efa, 14'h0105, 14'h0106, 14'h0106, 14'h0106,
                                  14'h0106, 14'h0100, 14'h0100, 14'h0082, 14'h3f7e, 14'h0083};
    logic [1:0]  ev_tab [12] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0};

    aux_temp_channel_threshold_regs DUT (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .accel_sample_strobe(accel_sample_strobe), .adc_sample(adc_sample),
        .temp_sample(temp_sample), .fifo_sample(fifo_sample), .fifo_channel_id(fifo_channel_id),
        .fifo_read(fifo_read), .adc_convert_enable(adc_convert_enable),
        .temp_convert_request(temp_convert_request), .fifo_readout_word(fifo_readout_word),
        .adc_act_event(adc_act_event), .adc_inact_event(adc_inact_event),
        .temp_act_event(temp_act_event), .temp_inact_event(temp_inact_event));

    // Clock and hang guard
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // APB master transfer
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, {2'h0, idx, 2'h0}, d, rd, err);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, {2'h0, idx, 2'h0}, 8'h0, rd, err);
        check($sformatf("reg %h", idx), {24'h0, exp}, rd);
    endtask

    // One sample strobe, outputs settled on return
    task automatic pulse(input logic [13:0] a, t);
        @(posedge sys_clk);
        accel_sample_strobe <= 1'b1;
        adc_sample <= a;
        temp_sample <= t;
        @(posedge sys_clk);
        accel_sample_strobe <= 1'b0;
        #1;
    endtask

    task automatic fifo_chk(input logic [1:0] fmt);
        logic [13:0] s;
        logic [15:0] exp;
        s = 14'h2a5b;
        @(posedge sys_clk);
        fifo_read <= 1'b1;
        fifo_sample <= s;
        fifo_channel_id <= 2'h2;
        @(posedge sys_clk);
        fifo_read <= 1'b0;
        #1;
        case (fmt)
            2'h3: exp = {2'h2, s};
            2'h2: exp = {4'h0, s[13:2]};
            2'h1: exp = {8'h0, s[13:6]};
            default: exp = {s[5:0], 2'h2, s[13], s[13], s[13:8]};
        endcase
        check("fifo word", {16'h0, exp}, {16'h0, fifo_readout_word});
    endtask

    task automatic t_fifo();
        fifo_chk(2'h3);
        for (int f = 0; f < 3; f++) begin
            wr_reg(8'h3c, {f[1:0], 6'h0});
            fifo_chk(f[1:0]);
        end
    endtask

    task automatic t_regs();
        logic [31:0] rd;
        logic        err;
        for (int i = 0; i < 7; i++) rd_chk(idx_tab[i], rst_tab[i]);
        for (int i = 0; i < 7; i++) begin
            wr_reg(idx_tab[i], 8'hff);
            rd_chk(idx_tab[i], msk_tab[i]);
        end
        apb(1'b0, 12'h114, 8'h0, rd, err);
        check("unmapped data", 32'h0, rd);
        check("unmapped err", 32'h1, {31'h0, err});
        apb(1'b1, 12'h0f1, 8'h00, rd, err);
        check("misaligned err", 32'h1, {31'h0, err});
        rd_chk(8'h3c, 8'hcf);
    endtask

    task automatic t_conv();
        wr_reg(8'h3c, 8'h01);
        wr_reg(8'h3d, 8'h00);
        @(posedge sys_clk);
        #1;
        check("adc enable", 32'h1, {31'h0, adc_convert_enable});
        pulse(14'h0, 14'h0);
        check("temp request", 32'h0, {31'h0, temp_convert_request});
        wr_reg(8'h3d, 8'h01);
        @(posedge sys_clk);
        #1;
        check("adc enable", 32'h0, {31'h0, adc_convert_enable});
        pulse(14'h0, 14'h0);
        check("temp request", 32'h1, {31'h0, temp_convert_request});
    endtask

    // ADC channel first, then temperature with ADC overridden
    task automatic t_detect();
        logic [3:0] got;
        wr_reg(8'h3e, 8'h04);
        wr_reg(8'h3f, 8'h14);
        wr_reg(8'h40, 8'h02);
        wr_reg(8'h41, 8'h0c);
        wr_reg(8'h42, 8'h23);
        wr_reg(8'h3c, 8'h0b);
        for (int ph = 0; ph < 2; ph++) begin
            wr_reg(8'h3d, ph ? 8'h0b : 8'h00);
            for (int i = 0; i < 12; i++) begin
                pulse(ph ? 14'h0 : smp_tab[i], ph ? smp_tab[i] : 14'h0);
                got = {adc_act_event, adc_inact_event, temp_act_event, temp_inact_event};
                check("events", {28'h0, ph ? {2'h0, ev_tab[i]} : {ev_tab[i], 2'h0}}, {28'h0, got});
            end
        end
        rd_chk(8'h50, 8'h0f);
        wr_reg(8'h50, 8'h0f);
        rd_chk(8'h50, 8'h00);
    endtask

    task automatic t_rereset();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(8'h3c, 8'hc0);
        rd_chk(8'h3f, 8'h00);
    endtask

    task automatic report_and_stop();
        $display("Errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_fifo();
        t_conv();
        t_detect();
        t_rereset();
        report_and_stop();
    end
endmodule // aux_temp_channel_threshold_regs_tb

bind aux_temp_channel_threshold_regs aux_temp_channel_threshold_regs_sva u_sva (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .accel_sample_strobe(accel_sample_strobe), .fifo_read(fifo_read),
    .adc_convert_enable(adc_convert_enable), .temp_convert_request(temp_convert_request),
    .fifo_readout_word(fifo_readout_word), .adc_act_event(adc_act_event),
    .adc_inact_event(adc_inact_event), .temp_act_event(temp_act_event),
    .temp_inact_event(temp_inact_event));
